// File: core/ssx_map.svh
// register map, flag layout, opcodes and timing of the shift/sub/xor slice
// Summary of operation
// - left shift zero fills, bit 7 to carry
// - arith right keeps bit 7, bit 0 carry
// - logic right clears bit 7, bit 0 carry
// - after shifts S, Z, parity; H, N cleared
// - shift takes 8, 15 or 23 states
// - subtract operand from accumulator, no carry in
// - sub flags: S, Z, H, overflow, N, borrow
// - xor operand into accumulator bit by bit
// - xor flags: S, Z, even parity, H set
// - sub, xor take 4, 7 or 19 states
// - memory shift result goes back in place
// - register field codes B..L, accumulator is 111
// - index address adds sign-extended displacement
`ifndef SSX_MAP_SVH
`define SSX_MAP_SVH
// byte addresses of the registers
`define SSX_OFS_INSTR 8'h00
`define SSX_OFS_OPERAND 8'h04
`define SSX_OFS_REGS_LO 8'h08
`define SSX_OFS_REGS_HI 8'h0c
`define SSX_OFS_INDEX 8'h10
`define SSX_OFS_STATUS 8'h14
`define SSX_RESP_OKAY 2'h0
`define SSX_RESP_SLVERR 2'h2
// status field positions
`define SSX_ST_BUSY 5'h00
`define SSX_ST_ILLEGAL 5'h01
`define SSX_ST_MCYC 5'h04
`define SSX_ST_TST 5'h08
`define SSX_ST_ADDR 5'h10
// flag bit positions within the flag byte
`define SSX_FLAG_C 3'h0
`define SSX_FLAG_N 3'h1
`define SSX_FLAG_PV 3'h2
`define SSX_FLAG_H 3'h4
`define SSX_FLAG_Z 3'h6
`define SSX_FLAG_S 3'h7
// register slots; code 110 means memory, its slot holds the flags
`define SSX_REG_H 3'h4
`define SSX_REG_L 3'h5
`define SSX_REG_MEM 3'h6
`define SSX_SLOT_F 3'h6
`define SSX_REG_A 3'h7
// prefixes, opcode bases (upper five bits) and the two full immediate opcodes
`define SSX_PFX_NONE 8'h00
`define SSX_PFX_BIT 8'hcb
`define SSX_PFX_IDX1 8'hdd
`define SSX_PFX_IDX2 8'hfd
`define SSX_OPC_ASL 5'h04
`define SSX_OPC_ASR 5'h05
`define SSX_OPC_LSR 5'h07
`define SSX_OPC_SUB 5'h12
`define SSX_OPC_XOR 5'h15
`define SSX_OPC_SUB_IMM 8'hd6
`define SSX_OPC_XOR_IMM 8'hee
// machine cycles and clock states, one state per clock
`define SSX_MC_SH_REG 3'h2
`define SSX_TS_SH_REG 5'h08
`define SSX_MC_SH_PTR 3'h4
`define SSX_TS_SH_PTR 5'h0f
`define SSX_MC_SH_IDX 3'h6
`define SSX_TS_SH_IDX 5'h17
`define SSX_MC_AC_REG 3'h1
`define SSX_TS_AC_REG 5'h04
`define SSX_MC_AC_MEM 3'h2
`define SSX_TS_AC_MEM 5'h07
`define SSX_MC_AC_IDX 3'h5
`define SSX_TS_AC_IDX 5'h13
// reset values
`define SSX_RST_BYTE 8'h00
`define SSX_RST_WORD 32'h0000_0000
`endif

// File: core/ssx_pkg.sv
// types shared by the shift/sub/xor slice
package ssx_pkg;
  typedef enum logic [2:0] {
    op_none,
    op_sub,
    op_xor,
    op_arith_shift_left,
    op_arith_shift_right,
    op_logic_shift_right
  } ssx_op_e;
  typedef enum logic [2:0] {
    md_reg,
    md_imm,
    md_pointer_pair,
    md_index_reg_first,
    md_index_reg_second
  } ssx_mode_e;
  typedef enum logic [1:0] {st_idle, st_decode, st_run} ssx_state_e;
  typedef logic [7:0] ssx_byte_t;
endpackage : ssx_pkg

// File: core/ssx_op_if.sv
// decoded operation and datapath signals between the slice's modules
`timescale 1ns/1ps
interface ssx_op_if;
  logic [31:0] instr;
  ssx_pkg::ssx_op_e op;
  ssx_pkg::ssx_mode_e mode;
  logic [2:0] sel;
  logic illegal;
  logic [2:0] mcyc;
  logic [4:0] tst;
  ssx_pkg::ssx_byte_t acc;
  ssx_pkg::ssx_byte_t opnd;
  ssx_pkg::ssx_byte_t flags_in;
  ssx_pkg::ssx_byte_t res;
  ssx_pkg::ssx_byte_t flags_out;
  modport dec (input instr, output op, mode, sel, illegal, mcyc, tst);
  modport alu (input op, acc, opnd, flags_in, output res, flags_out);
endinterface : ssx_op_if

// File: core/ssx_decode.sv
// opcode decoder: operation, operand form, register field, timing
`timescale 1ns/1ps
`include "ssx_map.svh"
module ssx_decode (
  ssx_op_if.dec d
);
  logic [7:0] pfx1;
  logic [7:0] pfx2;
  logic [7:0] opc;
  logic is_shift;

  function automatic ssx_pkg::ssx_op_e shift_of(input logic [4:0] base);
    case (base)
      `SSX_OPC_ASL: shift_of = ssx_pkg::op_arith_shift_left;
      `SSX_OPC_ASR: shift_of = ssx_pkg::op_arith_shift_right;
      `SSX_OPC_LSR: shift_of = ssx_pkg::op_logic_shift_right;
      default: shift_of = ssx_pkg::op_none;
    endcase
  endfunction : shift_of

  function automatic ssx_pkg::ssx_op_e acc_of(input logic [4:0] base);
    case (base)
      `SSX_OPC_SUB: acc_of = ssx_pkg::op_sub;
      `SSX_OPC_XOR: acc_of = ssx_pkg::op_xor;
      default: acc_of = ssx_pkg::op_none;
    endcase
  endfunction : acc_of

  // instruction word: prefix, second prefix, displacement, opcode
  assign pfx1 = d.instr[31:24];
  assign pfx2 = d.instr[23:16];
  assign opc = d.instr[7:0];
  assign d.sel = opc[2:0];

  // operation and operand form from prefixes and opcode
  always_comb begin
    d.op = ssx_pkg::op_none;
    d.mode = ssx_pkg::md_reg;
    if (pfx1 == `SSX_PFX_BIT && pfx2 == `SSX_PFX_NONE) begin
      d.op = shift_of(opc[7:3]);
      if (opc[2:0] == `SSX_REG_MEM) d.mode = ssx_pkg::md_pointer_pair;
    end else if (pfx1 == `SSX_PFX_NONE && pfx2 == `SSX_PFX_NONE) begin
      if (opc == `SSX_OPC_SUB_IMM) begin
        d.op = ssx_pkg::op_sub;
        d.mode = ssx_pkg::md_imm;
      end else if (opc == `SSX_OPC_XOR_IMM) begin
        d.op = ssx_pkg::op_xor;
        d.mode = ssx_pkg::md_imm;
      end else begin
        d.op = acc_of(opc[7:3]);
        if (opc[2:0] == `SSX_REG_MEM) d.mode = ssx_pkg::md_pointer_pair;
      end
    end else if (pfx1 == `SSX_PFX_IDX1 || pfx1 == `SSX_PFX_IDX2) begin
      d.mode = (pfx1 == `SSX_PFX_IDX1) ? ssx_pkg::md_index_reg_first :
        ssx_pkg::md_index_reg_second;
      if (opc[2:0] == `SSX_REG_MEM && pfx2 == `SSX_PFX_BIT) begin
        d.op = shift_of(opc[7:3]);
      end else if (opc[2:0] == `SSX_REG_MEM && pfx2 == `SSX_PFX_NONE) begin
        d.op = acc_of(opc[7:3]);
      end
    end
  end

  assign is_shift = d.op inside {ssx_pkg::op_arith_shift_left,
    ssx_pkg::op_arith_shift_right, ssx_pkg::op_logic_shift_right};

  // machine cycles and clock states of the decoded form
  always_comb begin
    d.illegal = (d.op == ssx_pkg::op_none);
    case (d.mode)
      ssx_pkg::md_reg: {d.mcyc, d.tst} = is_shift ?
        {`SSX_MC_SH_REG, `SSX_TS_SH_REG} : {`SSX_MC_AC_REG, `SSX_TS_AC_REG};
      ssx_pkg::md_imm, ssx_pkg::md_pointer_pair: {d.mcyc, d.tst} = is_shift ?
        {`SSX_MC_SH_PTR, `SSX_TS_SH_PTR} : {`SSX_MC_AC_MEM, `SSX_TS_AC_MEM};
      default: {d.mcyc, d.tst} = is_shift ?
        {`SSX_MC_SH_IDX, `SSX_TS_SH_IDX} : {`SSX_MC_AC_IDX, `SSX_TS_AC_IDX};
    endcase
  end
endmodule : ssx_decode

// File: core/ssx_alu.sv
// byte datapath: three shifts, subtract, exclusive-or and flags
`timescale 1ns/1ps
`include "ssx_map.svh"
module ssx_alu (
  ssx_op_if.alu a
);
  logic [8:0] diff;
  logic [4:0] hdiff;
  logic [7:0] r;
  logic cy;
  logic hc;
  logic pv;
  logic ng;

  // low nibble and full byte borrows
  assign diff = {1'b0, a.acc} - {1'b0, a.opnd};
  assign hdiff = {1'b0, a.acc[3:0]} - {1'b0, a.opnd[3:0]};

  // result and the flags that differ per operation
  always_comb begin
    r = a.opnd;
    cy = a.flags_in[`SSX_FLAG_C];
    hc = 1'b0;
    ng = 1'b0;
    pv = 1'b0;
    case (a.op)
      ssx_pkg::op_sub: begin
        r = diff[7:0];
        cy = diff[8];
        hc = hdiff[4];
        ng = 1'b1;
        pv = (a.acc[7] != a.opnd[7]) && (diff[7] != a.acc[7]);
      end
      ssx_pkg::op_xor: begin
        r = a.acc ^ a.opnd;
        hc = 1'b1;
        cy = 1'b0;
        pv = ~^(a.acc ^ a.opnd);
      end
      ssx_pkg::op_arith_shift_left: begin
        r = {a.opnd[6:0], 1'b0};
        cy = a.opnd[7];
        pv = ~^{a.opnd[6:0], 1'b0};
      end
      ssx_pkg::op_arith_shift_right: begin
        r = {a.opnd[7], a.opnd[7:1]};
        cy = a.opnd[0];
        pv = ~^{a.opnd[7], a.opnd[7:1]};
      end
      ssx_pkg::op_logic_shift_right: begin
        r = {1'b0, a.opnd[7:1]};
        cy = a.opnd[0];
        pv = ~^{1'b0, a.opnd[7:1]};
      end
      default: r = a.opnd;
    endcase
  end

  // flag byte; the two spare bits keep their old value
  always_comb begin
    a.res = r;
    a.flags_out = a.flags_in;
    a.flags_out[`SSX_FLAG_S] = r[7];
    a.flags_out[`SSX_FLAG_Z] = (r == 8'h00);
    a.flags_out[`SSX_FLAG_H] = hc;
    a.flags_out[`SSX_FLAG_PV] = pv;
    a.flags_out[`SSX_FLAG_N] = ng;
    a.flags_out[`SSX_FLAG_C] = cy;
  end
endmodule : ssx_alu

// File: core/ssx_core.sv
// slice top: register slave, operation sequencer and result checks
`timescale 1ns/1ps
`include "ssx_map.svh"
module ssx_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ssx_pkg::ssx_byte_t regs_r [8];
  ssx_pkg::ssx_byte_t regs_nxt [8];
  ssx_pkg::ssx_state_e state_r;
  ssx_pkg::ssx_state_e state_nxt;
  logic [31:0] instr_r;
  logic [31:0] instr_nxt;
  logic [7:0] operand_r;
  logic [7:0] operand_nxt;
  logic [15:0] idx1_r;
  logic [15:0] idx1_nxt;
  logic [15:0] idx2_r;
  logic [15:0] idx2_nxt;
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic illegal_r;
  logic illegal_nxt;
  logic [2:0] mcyc_r;
  logic [2:0] mcyc_nxt;
  logic [4:0] tst_r;
  logic [4:0] tst_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] rd_word;
  logic [31:0] lo_m;
  logic [31:0] hi_m;
  logic [31:0] idx_m;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic [7:0] disp;
  logic [7:0] opnd_sel;
  logic [15:0] ea;
  logic wr_fire;
  logic rd_fire;
  logic busy;
  logic commit;
  logic reg_mode;
  logic is_shift;

  ssx_op_if u_if ();

  // assertion clock and reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ssx_decode u_dec (
    .d(u_if)
  );

  ssx_alu u_alu (
    .a(u_if)
  );

  // byte-lane merge of a write into a word
  function automatic logic [31:0] ssx_merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) m[8*i +: 8] = wd[8*i +: 8];
    end
    return m;
  endfunction : ssx_merge

  // bus handshakes: address and data taken together, one at a time
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_fire = s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = rd_fire;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign wr_ofs = {s_axi_awaddr[7:2], 2'h0};
  assign rd_ofs = {s_axi_araddr[7:2], 2'h0};

  // merged views of the multi-byte registers
  assign lo_m = ssx_merge({regs_r[3], regs_r[2], regs_r[1], regs_r[0]},
    s_axi_wdata, s_axi_wstrb);
  assign hi_m = ssx_merge({regs_r[7], regs_r[6], regs_r[5], regs_r[4]},
    s_axi_wdata, s_axi_wstrb);
  assign idx_m = ssx_merge({idx2_r, idx1_r}, s_axi_wdata, s_axi_wstrb);

  // datapath operands and sequencing terms
  assign busy = (state_r != ssx_pkg::st_idle);
  assign commit = (state_r == ssx_pkg::st_run) && (cnt_r == 5'h01);
  assign reg_mode = (u_if.mode == ssx_pkg::md_reg);
  assign is_shift = u_if.op inside {ssx_pkg::op_arith_shift_left,
    ssx_pkg::op_arith_shift_right, ssx_pkg::op_logic_shift_right};
  assign opnd_sel = reg_mode ? regs_r[u_if.sel] : operand_r;
  assign disp = instr_r[15:8];
  assign u_if.instr = instr_r;
  assign u_if.acc = regs_r[`SSX_REG_A];
  assign u_if.opnd = opnd_sel;
  assign u_if.flags_in = regs_r[`SSX_SLOT_F];

  // effective address of a memory operand
  always_comb begin
    case (u_if.mode)
      ssx_pkg::md_pointer_pair: ea = {regs_r[`SSX_REG_H], regs_r[`SSX_REG_L]};
      ssx_pkg::md_index_reg_first: ea = idx1_r + {{8{disp[7]}}, disp};
      ssx_pkg::md_index_reg_second: ea = idx2_r + {{8{disp[7]}}, disp};
      default: ea = 16'h0000;
    endcase
  end

  // read data selection
  always_comb begin
    rd_word = `SSX_RST_WORD;
    case (rd_ofs)
      `SSX_OFS_INSTR: rd_word = instr_r;
      `SSX_OFS_OPERAND: rd_word = {24'h00_0000, operand_r};
      `SSX_OFS_REGS_LO: rd_word = {regs_r[3], regs_r[2], regs_r[1], regs_r[0]};
      `SSX_OFS_REGS_HI: rd_word = {regs_r[7], regs_r[6], regs_r[5], regs_r[4]};
      `SSX_OFS_INDEX: rd_word = {idx2_r, idx1_r};
      `SSX_OFS_STATUS: begin
        rd_word[`SSX_ST_BUSY] = busy;
        rd_word[`SSX_ST_ILLEGAL] = illegal_r;
        rd_word[`SSX_ST_MCYC +: 3] = mcyc_r;
        rd_word[`SSX_ST_TST +: 5] = tst_r;
        rd_word[`SSX_ST_ADDR +: 16] = addr_r;
      end
      default: rd_word = `SSX_RST_WORD;
    endcase
  end

  // bus response next state
  always_comb begin
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = (wr_ofs <= `SSX_OFS_STATUS) ? `SSX_RESP_OKAY :
        `SSX_RESP_SLVERR;
    end
    if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_word;
      rresp_nxt = (rd_ofs <= `SSX_OFS_STATUS) ? `SSX_RESP_OKAY :
        `SSX_RESP_SLVERR;
    end
  end

  // bus response registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `SSX_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `SSX_RESP_OKAY;
      rdata_r <= `SSX_RST_WORD;
    end else begin
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // register writes and the decode/run sequence
  always_comb begin
    regs_nxt = regs_r;
    state_nxt = state_r;
    instr_nxt = instr_r;
    operand_nxt = operand_r;
    idx1_nxt = idx1_r;
    idx2_nxt = idx2_r;
    addr_nxt = addr_r;
    cnt_nxt = cnt_r;
    illegal_nxt = illegal_r;
    mcyc_nxt = mcyc_r;
    tst_nxt = tst_r;
    if (wr_fire && !busy) begin
      case (wr_ofs)
        `SSX_OFS_INSTR: begin
          instr_nxt = ssx_merge(instr_r, s_axi_wdata, s_axi_wstrb);
          state_nxt = ssx_pkg::st_decode;
        end
        `SSX_OFS_OPERAND: begin
          if (s_axi_wstrb[0]) operand_nxt = s_axi_wdata[7:0];
        end
        `SSX_OFS_REGS_LO: begin
          for (int i = 0; i < 4; i++) regs_nxt[i] = lo_m[8*i +: 8];
        end
        `SSX_OFS_REGS_HI: begin
          for (int i = 0; i < 4; i++) regs_nxt[i+4] = hi_m[8*i +: 8];
        end
        `SSX_OFS_INDEX: begin
          idx1_nxt = idx_m[15:0];
          idx2_nxt = idx_m[31:16];
        end
        default: ;
      endcase
    end
    case (state_r)
      ssx_pkg::st_idle: ;
      ssx_pkg::st_decode: begin
        illegal_nxt = u_if.illegal;
        mcyc_nxt = u_if.mcyc;
        tst_nxt = u_if.tst;
        cnt_nxt = u_if.tst;
        addr_nxt = ea;
        state_nxt = u_if.illegal ? ssx_pkg::st_idle : ssx_pkg::st_run;
      end
      ssx_pkg::st_run: begin
        cnt_nxt = cnt_r - 5'h01;
        if (cnt_r == 5'h01) begin
          state_nxt = ssx_pkg::st_idle;
          regs_nxt[`SSX_SLOT_F] = u_if.flags_out;
          if (!is_shift) regs_nxt[`SSX_REG_A] = u_if.res;
          else if (reg_mode) regs_nxt[u_if.sel] = u_if.res;
          else operand_nxt = u_if.res;
        end
      end
      default: state_nxt = ssx_pkg::st_idle;
    endcase
  end

  // sequencer and register file state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs_r <= '{default: `SSX_RST_BYTE};
      state_r <= ssx_pkg::st_idle;
      instr_r <= `SSX_RST_WORD;
      operand_r <= `SSX_RST_BYTE;
      idx1_r <= 16'h0000;
      idx2_r <= 16'h0000;
      addr_r <= 16'h0000;
      cnt_r <= 5'h00;
      illegal_r <= 1'b0;
      mcyc_r <= 3'h0;
      tst_r <= 5'h00;
    end else begin
      regs_r <= regs_nxt;
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      operand_r <= operand_nxt;
      idx1_r <= idx1_nxt;
      idx2_r <= idx2_nxt;
      addr_r <= addr_nxt;
      cnt_r <= cnt_nxt;
      illegal_r <= illegal_nxt;
      mcyc_r <= mcyc_nxt;
      tst_r <= tst_nxt;
    end
  end

  // result checks
  sequence s_go_shift_reg;
    state_r == ssx_pkg::st_decode && !u_if.illegal && is_shift && reg_mode;
  endsequence

  sequence s_go_acc_imm;
    state_r == ssx_pkg::st_decode && !u_if.illegal && !is_shift &&
      u_if.mode == ssx_pkg::md_imm;
  endsequence

  property p_asl;
    logic [7:0] v;
    (commit && u_if.op == ssx_pkg::op_arith_shift_left && reg_mode,
      v = opnd_sel) |=> regs_r[u_if.sel] == {v[6:0], 1'b0} &&
      regs_r[`SSX_SLOT_F][`SSX_FLAG_C] == v[7];
  endproperty

  property p_asr;
    logic [7:0] v;
    (commit && u_if.op == ssx_pkg::op_arith_shift_right && !reg_mode,
      v = opnd_sel) |=> operand_r == {v[7], v[7:1]} &&
      regs_r[`SSX_SLOT_F][`SSX_FLAG_C] == v[0];
  endproperty

  property p_lsr;
    logic [7:0] v;
    (commit && u_if.op == ssx_pkg::op_logic_shift_right && reg_mode,
      v = opnd_sel) |=> regs_r[u_if.sel] == {1'b0, v[7:1]} &&
      regs_r[`SSX_SLOT_F][`SSX_FLAG_C] == v[0];
  endproperty

  property p_sub;
    logic [7:0] v;
    logic [7:0] w;
    (commit && u_if.op == ssx_pkg::op_sub, v = u_if.acc, w = opnd_sel)
      |=> regs_r[`SSX_REG_A] == v - w;
  endproperty

  property p_sub_flags;
    logic [7:0] v;
    logic [7:0] w;
    (commit && u_if.op == ssx_pkg::op_sub, v = u_if.acc, w = opnd_sel)
      |=> regs_r[`SSX_SLOT_F][`SSX_FLAG_C] == (v < w) &&
      regs_r[`SSX_SLOT_F][`SSX_FLAG_H] == (v[3:0] < w[3:0]) &&
      regs_r[`SSX_SLOT_F][`SSX_FLAG_N] &&
      regs_r[`SSX_SLOT_F][`SSX_FLAG_PV] ==
      ((v[7] != w[7]) && (regs_r[`SSX_REG_A][7] != v[7]));
  endproperty

  property p_xor;
    logic [7:0] v;
    logic [7:0] w;
    (commit && u_if.op == ssx_pkg::op_xor, v = u_if.acc, w = opnd_sel)
      |=> regs_r[`SSX_REG_A] == (v ^ w);
  endproperty

  property p_index_addr;
    logic [15:0] v;
    logic [7:0] dd;
    (state_r == ssx_pkg::st_decode &&
      u_if.mode == ssx_pkg::md_index_reg_first, v = idx1_r, dd = disp)
      |=> addr_r == v + {{8{dd[7]}}, dd};
  endproperty

  AST_ASL:
  assert property (p_asl) else $error("left shift result or carry wrong");
  AST_ASR:
  assert property (p_asr) else $error("arith right shift wrong");
  AST_LSR:
  assert property (p_lsr) else $error("logic right shift wrong");
  AST_SHIFT_FLAGS:
  assert property (commit && is_shift && reg_mode |=>
    !regs_r[`SSX_SLOT_F][`SSX_FLAG_H] && !regs_r[`SSX_SLOT_F][`SSX_FLAG_N] &&
    regs_r[`SSX_SLOT_F][`SSX_FLAG_S] == regs_r[u_if.sel][7] &&
    regs_r[`SSX_SLOT_F][`SSX_FLAG_Z] == (regs_r[u_if.sel] == 8'h00) &&
    regs_r[`SSX_SLOT_F][`SSX_FLAG_PV] == ~^regs_r[u_if.sel])
    else $error("shift flags wrong");
  AST_SHIFT_REG_TIME:
  assert property (s_go_shift_reg |=>
    (state_r == ssx_pkg::st_run) [*8] ##1 state_r == ssx_pkg::st_idle)
    else $error("register shift not 8 states");
  AST_SUB:
  assert property (p_sub) else $error("difference wrong");
  AST_SUB_FLAGS:
  assert property (p_sub_flags) else $error("subtract flags wrong");
  AST_XOR:
  assert property (p_xor) else $error("exclusive-or result wrong");
  AST_XOR_FLAGS:
  assert property (commit && u_if.op == ssx_pkg::op_xor |=>
    regs_r[`SSX_SLOT_F][`SSX_FLAG_H] && !regs_r[`SSX_SLOT_F][`SSX_FLAG_N] &&
    !regs_r[`SSX_SLOT_F][`SSX_FLAG_C] &&
    regs_r[`SSX_SLOT_F][`SSX_FLAG_PV] == ~^regs_r[`SSX_REG_A])
    else $error("exclusive-or flags wrong");
  AST_ACC_IMM_TIME:
  assert property (s_go_acc_imm |=>
    (state_r == ssx_pkg::st_run) [*7] ##1 state_r == ssx_pkg::st_idle)
    else $error("immediate operation not 7 states");
  AST_WRITEBACK:
  assert property (commit && is_shift && !reg_mode |=>
    operand_r == $past(u_if.res) && $stable(regs_r[`SSX_REG_A]))
    else $error("memory result not written back");
  AST_INDEX_ADDR:
  assert property (p_index_addr) else $error("indexed address wrong");
endmodule : ssx_core

// File: bench/ssx_master.sv
// register bus master model for the slice bench
`timescale 1ns/1ps
module ssx_master (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  output logic hang
);
  // idle bus at time zero
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    hang = 1'b0;
  end
  // bounded wait for one handshake kind
  task automatic wt(input int k);
    for (int i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (k == 1 ? s_axi_awready && s_axi_wready : k == 2 ? s_axi_bvalid :
          k == 3 ? s_axi_arready : s_axi_rvalid)
        return;
    end
    hang <= 1'b1;
  endtask : wt
  // write: both channels together, payload inverted once released
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    wt(1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~d;
    wt(2);
  endtask : wr
  // read: data taken at the edge that shows it valid
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    wt(3);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    wt(4);
    d = s_axi_rdata;
  endtask : rd
endmodule : ssx_master

// File: bench/tb_shift_subtract_xor_alu.sv
// self-checking bench for the shift/sub/xor slice
`timescale 1ns/1ps
module tb_shift_subtract_xor_alu;
  localparam int TS[2][4] = '{'{8, 15, 0, 23}, '{4, 7, 7, 19}};
  localparam int MC[2][4] = '{'{2, 4, 0, 6}, '{1, 2, 2, 5}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, hang;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [65:0] qr[$];
  logic [1:0] qb[$];
  logic [65:0] nt;
  int err_total = 0;
  int n_checks = 0;
  int seed = 82;

  always #2.5 aclk = ~aclk;

  ssx_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1));
  ssx_master m (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rdata, .hang);

  task automatic chk(input logic [31:0] seen, exp, mk);
    n_checks++;
    if ((seen & mk) !== (exp & mk)) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // note the expected response, then issue the access
  task automatic wx(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    qb.push_back(r);
    m.wr(a, d);
  endtask : wx
  task automatic rx(input logic [7:0] a, input logic [31:0] v, mk,
                    input logic [1:0] r = 2'h0);
    qr.push_back({r, mk, v});
    m.rd(a, rd_d);
  endtask : rx

  // reference result and flag byte
  function automatic logic [15:0] ref_op(int k, logic [7:0] a, v, f);
    logic [7:0] r;
    logic c, h, p, n;
    h = 1'b0;
    n = 1'b0;
    case (k)
      0: {c, r} = {v, 1'b0};
      1: {r, c} = {v[7], v};
      2: {r, c} = {1'b0, v};
      3: begin
        {c, r} = {1'b0, a} - {1'b0, v};
        h = a[3:0] < v[3:0];
        n = 1'b1;
      end
      default: begin
        r = a ^ v;
        c = 1'b0;
        h = 1'b1;
      end
    endcase
    p = k == 3 ? (a[7] ^ v[7]) & (a[7] ^ r[7]) : ~^r;
    return {r, r[7], r == 8'h0, f[5], h, f[3], p, n, c};
  endfunction : ref_op

  // one operation: load state, start, check all it touched
  task automatic run(input int f, input int k);
    logic [63:0] rg;
    logic [31:0] op, xr;
    logic [15:0] ad, rf;
    logic [7:0] d, oc;
    logic [2:0] s;
    int j;
    rg = {$random(seed), $random(seed)};
    op = $random(seed);
    xr = $random(seed);
    d = 8'($random(seed));
    s = 3'($random(seed));
    if (s == 3'h6 || f > 0) s = f > 0 ? 3'h6 : 3'h7;
    ad = f == 1 ? {rg[39:32], rg[47:40]} :
      (op[8] ? xr[15:0] : xr[31:16]) + {{8{d[7]}}, d};
    oc = f == 2 ? (k == 3 ? 8'hd6 : 8'hee) : {k == 0 ? 5'h04 :
      k == 1 ? 5'h05 : k == 2 ? 5'h07 : k == 3 ? 5'h12 : 5'h15, s};
    wx(8'h08, rg[31:0]);
    wx(8'h0c, rg[63:32]);
    wx(8'h04, op);
    wx(8'h10, xr);
    wx(8'h00, {f == 3 ? (op[8] ? 8'hdd : 8'hfd) : k < 3 ? 8'hcb : 8'h00,
      f == 3 && k < 3 ? 8'hcb : 8'h00, f == 3 ? d : 8'h00, oc});
    wx(8'h08, ~rg[31:0]);
    if (k < 3) rx(8'h14, 32'h1, 32'h1);
    j = 0;
    do begin
      rx(8'h14, 32'h0, 32'h0);
      j++;
    end while (rd_d[0] !== 1'b0 && j < 60);
    if (rd_d[0] !== 1'b0) begin
      err_total++;
      finish_test;
    end
    rf = ref_op(k, rg[63:56], f == 0 ? rg[{s, 3'h0} +: 8] : op[7:0],
      rg[55:48]);
    if (k > 2) rg[63:56] = rf[15:8];
    else if (f == 0) rg[{s, 3'h0} +: 8] = rf[15:8];
    else op[7:0] = rf[15:8];
    rg[55:48] = rf[7:0];
    rx(8'h08, rg[31:0], 32'hffff_ffff);
    rx(8'h0c, rg[63:32], 32'hffff_ffff);
    rx(8'h04, {24'h0, op[7:0]}, 32'hffff_ffff);
    rx(8'h14, {ad, 3'h0, 5'(TS[k > 2][f]), 1'b0, 3'(MC[k > 2][f]), 4'h0},
      f[0] ? 32'hffff_1f73 : 32'h1f73);
  endtask : run

  // compare each answer with the oldest note
  always @(posedge aclk) begin
    if (aresetn && s_axi_bvalid)
      chk({30'h0, s_axi_bresp}, {30'h0, qb.pop_front()}, 32'h3);
    if (aresetn && s_axi_rvalid) begin
      nt = qr.pop_front();
      chk({30'h0, s_axi_rresp}, {30'h0, nt[65:64]}, 32'h3);
      chk(s_axi_rdata, nt[31:0], nt[63:32]);
    end
  end

  always @(posedge hang) begin
    err_total++;
    finish_test;
  end

  // reset, map checks, then every operation and operand form
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rx(8'(i * 4), 32'h0, 32'hffff_ffff);
    rx(8'h18, 32'h0, 32'hffff_ffff, 2'h2);
    wx(8'h18, 32'h1, 2'h2);
    wx(8'h00, 32'h0000_0020);
    rx(8'h14, 32'h2, 32'h3);
    for (int r = 0; r < 3; r++)
      for (int f = 0; f < 4; f++)
        for (int k = 0; k < 5; k++)
          if (f != 2 || k > 2) run(f, k);
    finish_test;
  end
endmodule : tb_shift_subtract_xor_alu
